// ==== rtl/mm_master_pkg.sv ====
// Shared widths, constants and types of the bus master transfer engine
`default_nettype none

package mm_master_pkg;

   // Bus widths
   localparam int ADDR_W = 32;
   localparam int DATA_W = 32;
   localparam int BE_W = 4;
   localparam int BURST_W = 4;
   localparam int CNT_W = 8;

   // Read return buffer shape
   localparam int BUF_DEPTH = 2;
   localparam int PTR_W = 1;
   localparam int OCC_W = 2;

   typedef logic [ADDR_W-1:0] addr_t;
   typedef logic [DATA_W-1:0] data_t;
   typedef logic [BE_W-1:0] be_t;
   typedef logic [BURST_W-1:0] len_t;
   typedef logic [CNT_W-1:0] cnt_t;
   typedef logic [OCC_W-1:0] occ_t;

   // Fixed values used by the logic
   localparam be_t BE_ALL = 4'hF;
   localparam len_t LEN_ONE = 4'h1;
   localparam len_t LEN_ZERO = 4'h0;
   localparam cnt_t CNT_ONE = 8'h01;
   localparam cnt_t CNT_ZERO = 8'h00;
   localparam cnt_t RD_CREDITS = 8'h02;

   typedef enum logic {CMD_READ, CMD_WRITE} cmd_kind_e;

endpackage : mm_master_pkg

`default_nettype wire

// ==== rtl/rsp_if.sv ====
// Read word path from the bus side into the return buffer
`default_nettype none

interface rsp_if;
   import mm_master_pkg::*;
   logic valid;
   logic ready;
   data_t data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface : rsp_if

`default_nettype wire

// ==== rtl/word_buf.sv ====
// Two-entry word buffer between bus read data and the user
`default_nettype none

module word_buf #(
   parameter int W = mm_master_pkg::DATA_W,
   parameter int DEPTH = mm_master_pkg::BUF_DEPTH
) (
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   rsp_if.snk in_s,
   output logic out_valid_o,
   output logic [W-1:0] out_data_o,
   input wire logic out_ready_i,
   output logic [mm_master_pkg::OCC_W-1:0] occ_o
);
   import mm_master_pkg::*;

   logic [W-1:0] mem_q [DEPTH];
   logic [PTR_W-1:0] wp_q;
   logic [PTR_W-1:0] rp_q;
   occ_t occ_q;
   logic push;
   logic pop;

   // Handshakes on both sides
   assign in_s.ready = ce_i && (occ_q != occ_t'(DEPTH));
   assign out_valid_o = occ_q != '0;
   assign out_data_o = mem_q[rp_q];
   assign occ_o = occ_q;
   assign push = in_s.valid && in_s.ready;
   assign pop = ce_i && out_valid_o && out_ready_i;

   // Storage, one entry per generate step
   for (genvar i = 0; i < DEPTH; i++)
   begin : g_entry
      always_ff @(posedge mclk_i)
      begin
         if (push && wp_q == PTR_W'(i))
         begin
            mem_q[i] <= in_s.data;
         end
      end
   end

   // Pointers and fill level
   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         wp_q <= '0;
         rp_q <= '0;
         occ_q <= '0;
      end
      else if (ce_i)
      begin
         if (push)
         begin
            wp_q <= (wp_q == PTR_W'(DEPTH - 1)) ? '0 : wp_q + PTR_W'(1);
         end
         if (pop)
         begin
            rp_q <= (rp_q == PTR_W'(DEPTH - 1)) ? '0 : rp_q + PTR_W'(1);
         end
         occ_q <= occ_q + occ_t'(push) - occ_t'(pop);
      end
   end

endmodule : word_buf

`default_nettype wire

// ==== rtl/rd_track.sv ====
// Count of read words still owed by the fabric
`default_nettype none

module rd_track (
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic add_i,
   input wire mm_master_pkg::len_t add_len_i,
   input wire logic dec_i,
   input wire logic clr_i,
   output mm_master_pkg::cnt_t cnt_o
);
   import mm_master_pkg::*;

   cnt_t cnt_d;

   // Discard drops all older words; a read taken at that edge still counts
   always_comb
   begin
      cnt_d = cnt_o;
      if (clr_i)
      begin
         cnt_d = CNT_ZERO;
      end
      else if (dec_i && cnt_o != CNT_ZERO)
      begin
         cnt_d = cnt_o - CNT_ONE;
      end
      if (add_i)
      begin
         cnt_d = cnt_d + cnt_t'(add_len_i);
      end
   end

   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         cnt_o <= CNT_ZERO;
      end
      else if (ce_i)
      begin
         cnt_o <= cnt_d;
      end
   end

endmodule : rd_track

`default_nettype wire

// ==== rtl/mm_master.sv ====
// Memory-mapped bus master: single, pipelined and burst transfers
//
// Notes on behaviour
// - A stalled transfer lasts stall cycles plus one; waiting never times out.
// - Without a usable lane mask every byte lane counts as enabled.
// - A transfer starts with address, lane mask and one strobe in cycle one.
// - While stall is high with a strobe out, all bus outputs stay unchanged next cycle.
// - Transfer ends at first edge with stall low; next may follow at once.
// - A one-bit response-valid input marks read words answering earlier reads.
// - Several reads may be outstanding; stall and response-valid both honoured.
// - A read issued with the discard gives the next valid response.
// - Read bursts use the pipelined response tracking.
// - One address plus burst length at burst start; slave derives the rest.
// - A burst of length B commits to B transfers, never abandoned.
// - A new read may start before older data returns only while owed, buffered and new words fit the two-entry buffer.
// - Write burst opens with address, word, strobe, mask and length together.
// - Address and burst length hold until the last write word is accepted.
// - Write burst pauses by dropping strobe; under stall with strobe high all outputs hold.
// - Read address phase ends on stall low; data phase ends after length words.
// - Every cycle with response-valid high its read word is captured.
// - Lane mask holds through the whole read address phase.
// - Discard is raised together with a new read or write command.
// - Burst length output of configurable width gives transfers per burst.
`default_nettype none

module mm_master (
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // User command port
   input wire logic cmd_valid_i,
   output logic cmd_ready_o,
   input wire mm_master_pkg::cmd_kind_e cmd_kind_i,
   input wire mm_master_pkg::addr_t cmd_addr_i,
   input wire mm_master_pkg::be_t cmd_be_i,
   input wire mm_master_pkg::len_t cmd_len_i,
   input wire logic cmd_flush_i,
   // User write words
   input wire logic wr_valid_i,
   input wire mm_master_pkg::data_t wr_data_i,
   output logic wr_ready_o,
   // User read words
   output logic rsp_valid_o,
   output mm_master_pkg::data_t rsp_data_o,
   input wire logic rsp_ready_i,
   // Bus side
   output mm_master_pkg::addr_t addr_o,
   output mm_master_pkg::be_t be_o,
   output mm_master_pkg::len_t burst_o,
   output logic read_o,
   output logic write_o,
   output mm_master_pkg::data_t wdata_o,
   output logic flush_o,
   input wire logic stall_i,
   input wire logic rdv_i,
   input wire mm_master_pkg::data_t rdata_i,
   // Status
   output logic busy_o,
   output mm_master_pkg::cnt_t pend_o
);
   import mm_master_pkg::*;

   typedef enum logic [1:0] {ST_IDLE, ST_RADDR, ST_WBURST} state_e;

   state_e state_q;
   addr_t addr_q;
   be_t be_q;
   len_t burst_q;
   logic read_q;
   logic write_q;
   data_t wdata_q;
   logic flush_q;
   len_t wsent_q;
   len_t loaded_q;

   logic rd_done;
   logic wr_acc;
   logic wr_last;
   logic free;
   logic take;
   logic take_rd;
   logic take_wr;
   logic wr_load;
   logic slot_free;
   logic rd_room;
   logic cmd_ok;
   len_t len_eff;
   be_t be_eff;
   cnt_t rd_need;
   cnt_t pend;
   occ_t occ;

   rsp_if rx ();

   // Bus outputs straight from flops
   assign addr_o = addr_q;
   assign be_o = be_q;
   assign burst_o = burst_q;
   assign read_o = read_q;
   assign write_o = write_q;
   assign wdata_o = wdata_q;
   assign flush_o = flush_q;
   assign pend_o = pend;
   assign busy_o = (state_q != ST_IDLE) || (pend != CNT_ZERO);

   // Completion of the current bus transfer
   assign rd_done = (state_q == ST_RADDR) && read_q && !stall_i;
   assign wr_acc = (state_q == ST_WBURST) && write_q && !stall_i;
   assign wr_last = wr_acc && (wsent_q == burst_q - LEN_ONE);
   assign free = (state_q == ST_IDLE) || rd_done || wr_last;

   // Zero length means one word; empty mask means all lanes
   assign len_eff = (cmd_len_i == LEN_ZERO) ? LEN_ONE : cmd_len_i;
   assign be_eff = (cmd_be_i == '0) ? BE_ALL : cmd_be_i;

   // Read credit: owed words plus buffered words must fit the buffer
   always_comb
   begin
      rd_need = pend + cnt_t'(occ) + cnt_t'(len_eff);
      if (rd_done)
      begin
         rd_need = rd_need + cnt_t'(burst_q);
      end
      rd_room = rd_need <= RD_CREDITS;
   end

   // A write needs its first word ready with the command
   assign cmd_ok = (cmd_kind_i == CMD_READ) ? rd_room : wr_valid_i;
   assign cmd_ready_o = ce_i && free && cmd_ok;
   assign take = cmd_valid_i && cmd_ready_o;
   assign take_rd = take && (cmd_kind_i == CMD_READ);
   assign take_wr = take && (cmd_kind_i == CMD_WRITE);

   // Later burst words load whenever the output slot is free
   assign slot_free = !write_q || !stall_i;
   assign wr_load = (state_q == ST_WBURST) && slot_free && (loaded_q != burst_q) && wr_valid_i;
   assign wr_ready_o = ce_i && (take_wr || ((state_q == ST_WBURST) && slot_free && (loaded_q != burst_q)));

   // Transfer state
   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         state_q <= ST_IDLE;
      end
      else if (ce_i)
      begin
         if (take_rd)
         begin
            state_q <= ST_RADDR;
         end
         else if (take_wr)
         begin
            state_q <= ST_WBURST;
         end
         else if (rd_done || wr_last)
         begin
            state_q <= ST_IDLE;
         end
      end
   end

   // Address, mask and length change only when a command is taken
   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         addr_q <= '0;
         be_q <= '0;
         burst_q <= LEN_ZERO;
      end
      else if (ce_i && take)
      begin
         addr_q <= cmd_addr_i;
         be_q <= be_eff;
         burst_q <= len_eff;
      end
   end

   // Read strobe
   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         read_q <= 1'b0;
      end
      else if (ce_i)
      begin
         if (take_rd)
         begin
            read_q <= 1'b1;
         end
         else if (rd_done || take_wr)
         begin
            read_q <= 1'b0;
         end
      end
   end

   // Write strobe and word; a missing user word pauses the burst
   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         write_q <= 1'b0;
         wdata_q <= '0;
      end
      else if (ce_i)
      begin
         if (take_wr || wr_load)
         begin
            write_q <= 1'b1;
            wdata_q <= wr_data_i;
         end
         else if (wr_acc || take_rd)
         begin
            write_q <= 1'b0;
         end
      end
   end

   // Discard rides with the first transfer of its command
   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         flush_q <= 1'b0;
      end
      else if (ce_i)
      begin
         if (take)
         begin
            flush_q <= cmd_flush_i;
         end
         else if ((read_q || write_q) && !stall_i)
         begin
            flush_q <= 1'b0;
         end
      end
   end

   // Words loaded and words accepted within a write burst
   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         wsent_q <= LEN_ZERO;
         loaded_q <= LEN_ZERO;
      end
      else if (ce_i)
      begin
         if (take_wr)
         begin
            wsent_q <= LEN_ZERO;
            loaded_q <= LEN_ONE;
         end
         else
         begin
            if (wr_acc)
            begin
               wsent_q <= wsent_q + LEN_ONE;
            end
            if (wr_load)
            begin
               loaded_q <= loaded_q + LEN_ONE;
            end
         end
      end
   end

   // Outstanding read words; a read taken with the discard survives it
   rd_track u_track (
      .mclk_i (mclk_i),
      .rst_i (rst_i),
      .ce_i (ce_i),
      .add_i (rd_done),
      .add_len_i (burst_q),
      .dec_i (rdv_i),
      .clr_i (flush_q),
      .cnt_o (pend)
   );

   // Every valid read word goes into the return buffer
   assign rx.valid = ce_i && rdv_i;
   assign rx.data = rdata_i;

   word_buf #(
      .W (DATA_W),
      .DEPTH (BUF_DEPTH)
   ) u_buf (
      .mclk_i (mclk_i),
      .rst_i (rst_i),
      .ce_i (ce_i),
      .in_s (rx),
      .out_valid_o (rsp_valid_o),
      .out_data_o (rsp_data_o),
      .out_ready_i (rsp_ready_i),
      .occ_o (occ)
   );

   // Checks next to the logic
   a_stall_hold_all: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      (read_o || write_o) && stall_i |=> $stable(addr_o) && $stable(be_o) && $stable(wdata_o)
         && $stable(read_o) && $stable(write_o) && $stable(burst_o) && $stable(flush_o))
      else $error("bus outputs moved during stall");

   a_stall_waits: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      read_o && stall_i ##1 stall_i |-> read_o)
      else $error("read dropped while stalled");

   a_cmd_starts: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      take |=> (read_o ^ write_o) && (addr_o == $past(cmd_addr_i)))
      else $error("taken command not driven next cycle");

   a_back_to_back: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      ce_i && rd_done && cmd_valid_i && cmd_kind_i == CMD_WRITE && wr_valid_i |-> cmd_ready_o)
      else $error("next transfer held off after completion");

   a_burst_addr_hold: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      ce_i && state_q == ST_WBURST && !wr_last |=> $stable(addr_o) && $stable(burst_o)
         && state_q == ST_WBURST)
      else $error("write burst address or length changed");

   a_rd_mask_hold: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      ce_i && state_q == ST_RADDR && !rd_done |=> $stable(be_o))
      else $error("lane mask moved in read address phase");

   a_rd_word_kept: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      ce_i && rdv_i |-> rx.ready)
      else $error("read word arrived with buffer full");

   a_flush_clears: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      ce_i && flush_o && !rd_done |=> pend == CNT_ZERO)
      else $error("outstanding count survived discard");

   a_count_adds: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      ce_i && rd_done && !flush_o && !rdv_i |=> pend == $past(pend) + cnt_t'($past(burst_o)))
      else $error("accepted read length not counted");

   a_mask_full: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      take && cmd_be_i == '0 |=> be_o == BE_ALL)
      else $error("empty mask not widened to all lanes");

endmodule : mm_master

`default_nettype wire

// ==== tb/fabric_model.sv ====
// Fabric model: random stall, in-order read returns, discard of owed words
`default_nettype none

module fabric_model (
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic [1:0] mode_i,
   input wire mm_master_pkg::addr_t addr_i,
   input wire mm_master_pkg::len_t burst_i,
   input wire logic read_i,
   input wire logic flush_i,
   output logic stall_o,
   output logic rdv_o,
   output mm_master_pkg::data_t rdata_o
);
   timeunit 1ns;
   timeprecision 100ps;
   import mm_master_pkg::*;

   data_t owed_q[$];
   int n;

   // Mode 0 prompt, 1 random stalls and gaps, 2 withhold all answers
   always @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         owed_q.delete();
         stall_o <= 1'b0;
         rdv_o <= 1'b0;
         rdata_o <= 32'h0;
      end
      else
      begin
         if (flush_i)
            owed_q.delete();
         if (read_i && !stall_o)
         begin
            n = (burst_i == 4'h0) ? 1 : int'(burst_i);
            for (int k = 0; k < n; k++)
               owed_q.push_back(~(addr_i + 32'(4 * k)));
         end
         // Single master here, so a burst never loses its slave
         stall_o <= (mode_i == 2'h1) ? 1'($urandom % 2) : 1'b0;
         if (mode_i != 2'h2 && owed_q.size() > 0 && (mode_i == 2'h0 || $urandom % 2 == 0))
         begin
            rdv_o <= 1'b1;
            rdata_o <= owed_q.pop_front();
         end
         else
         begin
            rdv_o <= 1'b0;
            rdata_o <= ~rdata_o; // Stale word never repeats
         end
      end
   end
endmodule : fabric_model

`default_nettype wire

// ==== tb/tb.sv ====
// Self-checking bench of the bus master against the fabric model
`default_nettype none

module tb;
   timeunit 1ns;
   timeprecision 100ps;
   import mm_master_pkg::*;

   typedef struct {logic wr; addr_t a; be_t be; len_t len; logic fl; data_t d;} exp_s;
   logic mclk_i = 1'b0;
   logic rst_i = 1'b1;
   logic ce_i = 1'b1;
   logic cmd_valid_i = 1'b0;
   cmd_kind_e cmd_kind_i = CMD_READ;
   addr_t cmd_addr_i = '0;
   be_t cmd_be_i = '0;
   len_t cmd_len_i = '0;
   logic cmd_flush_i = 1'b0;
   logic wr_valid_i = 1'b0;
   data_t wr_data_i = '0;
   logic rsp_ready_i = 1'b0;
   logic cmd_ready_o, wr_ready_o, rsp_valid_o, read_o, write_o, flush_o, stall_i, rdv_i, busy_o;
   data_t rsp_data_o, wdata_o, rdata_i;
   addr_t addr_o;
   be_t be_o;
   len_t burst_o;
   cnt_t pend_o;
   logic [1:0] fab_mode = 2'h0;
   int rdy_mode = 1;
   int n_mismatch = 0;
   int n_checks = 0;
   int unsigned sd;
   exp_s bq[$];
   data_t rq[$];
   exp_s e;
   logic [79:0] snap;
   logic held = 1'b0;

   always #12.5 mclk_i = ~mclk_i;

   mm_master dut (.mclk_i(mclk_i), .rst_i(rst_i), .ce_i(ce_i), .cmd_valid_i(cmd_valid_i),
      .cmd_ready_o(cmd_ready_o), .cmd_kind_i(cmd_kind_i), .cmd_addr_i(cmd_addr_i), .cmd_be_i(cmd_be_i),
      .cmd_len_i(cmd_len_i), .cmd_flush_i(cmd_flush_i), .wr_valid_i(wr_valid_i), .wr_data_i(wr_data_i),
      .wr_ready_o(wr_ready_o), .rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o), .rsp_ready_i(rsp_ready_i),
      .addr_o(addr_o), .be_o(be_o), .burst_o(burst_o), .read_o(read_o), .write_o(write_o), .wdata_o(wdata_o),
      .flush_o(flush_o), .stall_i(stall_i), .rdv_i(rdv_i), .rdata_i(rdata_i), .busy_o(busy_o), .pend_o(pend_o));

   fabric_model fab (.mclk_i(mclk_i), .rst_i(rst_i), .mode_i(fab_mode), .addr_i(addr_o), .burst_i(burst_o),
      .read_i(read_o), .flush_i(flush_o), .stall_o(stall_i), .rdv_o(rdv_i), .rdata_o(rdata_i));

   // Compare one value and count it
   task automatic chk(input string what, input logic [79:0] seen, input logic [79:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   // Counts and verdict, then end of run
   task automatic finish_test();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : finish_test

   // Hold request until a ready seen before the edge, bounded
   task automatic wait_rdy(input logic sel);
      logic ok;
      for (int t = 0; t < 500; t++)
      begin
         @(negedge mclk_i);
         ok = sel ? wr_ready_o : cmd_ready_o;
         @(posedge mclk_i);
         if (ok === 1'b1)
            return;
      end
      $display("ERROR handshake expected 1 seen 0");
      n_mismatch++;
      finish_test();
   endtask : wait_rdy

   // One command with its write words; expected bus and read words noted
   task automatic issue(input logic wr, input addr_t a, input be_t be, input len_t len, input logic fl,
                        input logic xr);
      int n;
      data_t w;
      exp_s x;
      n = (len == 4'h0) ? 1 : int'(len);
      w = $urandom;
      x = '{wr, a, (be == 4'h0) ? BE_ALL : be, (len == 4'h0) ? LEN_ONE : len, fl, wr ? w : 32'h0};
      bq.push_back(x);
      for (int k = 0; k < n && !wr && xr; k++)
         rq.push_back(~(a + 32'(4 * k)));
      cmd_valid_i <= 1'b1;
      cmd_kind_i <= wr ? CMD_WRITE : CMD_READ;
      cmd_addr_i <= a;
      cmd_be_i <= be;
      cmd_len_i <= len;
      cmd_flush_i <= fl;
      wr_valid_i <= wr;
      wr_data_i <= w;
      wait_rdy(1'b0);
      if (wr && n > 1)
         cmd_valid_i <= 1'b0;
      for (int k = 1; k < n && wr; k++)
      begin
         if (fab_mode == 2'h1 && $urandom % 3 == 0)
         begin
            wr_valid_i <= 1'b0; // Pause the burst
            @(posedge mclk_i);
         end
         w = $urandom;
         x.fl = 1'b0;
         x.d = w;
         bq.push_back(x);
         wr_valid_i <= 1'b1;
         wr_data_i <= w;
         wait_rdy(1'b1);
      end
   endtask : issue

   // Withdraw command and write word requests
   task automatic stop();
      cmd_valid_i <= 1'b0;
      wr_valid_i <= 1'b0;
      @(posedge mclk_i);
   endtask : stop

   // Bounded wait for all traffic to drain
   task automatic wait_idle(input string name);
      for (int t = 0; t < 3000; t++)
      begin
         @(negedge mclk_i);
         if (busy_o === 1'b0 && rsp_valid_o === 1'b0 && rq.size() == 0 && bq.size() == 0)
         begin
            $display("test %s done", name);
            // Hand back just after a rising edge, where the next request may start
            @(posedge mclk_i);
            return;
         end
      end
      $display("ERROR drain expected idle seen busy");
      n_mismatch++;
      finish_test();
   endtask : wait_idle

   // Random mix of reads, read bursts and write bursts, back to back
   task automatic run_mix(input int n);
      logic wr;
      for (int i = 0; i < n; i++)
      begin
         wr = 1'($urandom % 2);
         issue(wr, $urandom & 32'hFFFF_FFFC, 4'($urandom), wr ? 4'($urandom % 5) : 4'(1 + $urandom % 2), 1'b0,
               1'b1);
      end
   endtask : run_mix

   // User read side: stalled, always ready, or random
   always @(posedge mclk_i)
      rsp_ready_i <= (rdy_mode == 2) ? 1'($urandom % 2) : (rdy_mode == 1);

   // Watch accepted bus transfers, stall holding and user read words
   always @(negedge mclk_i)
   begin
      if (held)
         chk("stall_hold", {addr_o, wdata_o, be_o, burst_o, read_o, write_o, flush_o, 5'h0}, snap);
      held = !rst_i && (read_o || write_o) && stall_i === 1'b1;
      snap = {addr_o, wdata_o, be_o, burst_o, read_o, write_o, flush_o, 5'h0};
      if (!rst_i && (read_o || write_o) && stall_i === 1'b0)
      begin
         e = (bq.size() > 0) ? bq.pop_front() : exp_s'{1'b1, 32'h0, 4'h0, 4'h0, 1'b1, 32'h0};
         chk("write_o", write_o, e.wr);
         chk("addr_o", addr_o, e.a);
         chk("be_o", be_o, e.be);
         chk("burst_o", burst_o, e.len);
         chk("flush_o", flush_o, e.fl);
         chk("wdata_o", e.wr ? wdata_o : 32'h0, e.d);
      end
      if (!rst_i && rsp_valid_o === 1'b1 && rsp_ready_i)
         chk("rsp_data_o", rsp_data_o, (rq.size() > 0) ? rq.pop_front() : ~rsp_data_o);
   end

   // Main sequence
   initial
   begin
      sd = $urandom(32'h3f26);
      repeat (6) @(posedge mclk_i);
      rst_i <= 1'b0;
      @(negedge mclk_i);
      chk("idle_outs", {read_o, write_o, rsp_valid_o, busy_o}, 4'h0);
      chk("pend_o", pend_o, 8'h00);
      $display("test reset done");
      @(posedge mclk_i);
      // Clock enable low: a waiting read is neither taken nor driven
      ce_i <= 1'b0;
      cmd_valid_i <= 1'b1;
      repeat (3) @(negedge mclk_i);
      chk("ce_hold", {cmd_ready_o, read_o, write_o, pend_o}, 11'h0);
      @(posedge mclk_i);
      ce_i <= 1'b1;
      cmd_valid_i <= 1'b0;
      @(posedge mclk_i);
      $display("test clock_enable done");
      run_mix(20);
      stop();
      wait_idle("prompt_mix");
      fab_mode <= 2'h1;
      rdy_mode <= 2;
      run_mix(40);
      stop();
      wait_idle("stall_mix");
      fab_mode <= 2'h0;
      rdy_mode <= 0;
      issue(1'b0, 32'h0000_0100, 4'h3, 4'h2, 1'b0, 1'b1);
      fork
         issue(1'b0, 32'h0000_0200, 4'h0, 4'h1, 1'b0, 1'b1);
         begin
            repeat (20) @(negedge mclk_i);
            chk("cmd_ready_o", cmd_ready_o, 1'b0);
            chk("rsp_valid_o", rsp_valid_o, 1'b1);
            rdy_mode <= 1;
         end
      join
      stop();
      wait_idle("buffer_full");
      // Discard with a new read, then with a new write
      for (int c = 0; c < 2; c++)
      begin
         fab_mode <= 2'h2;
         issue(1'b0, 32'h0000_0300, 4'hF, 4'h1, 1'b0, 1'b0);
         issue(c[0], 32'h0000_0400, 4'h5, 4'h1, 1'b1, 1'b1);
         stop();
         repeat (3) @(posedge mclk_i);
         fab_mode <= 2'h0;
         wait_idle("discard");
         chk("pend_o", pend_o, 8'h00);
         @(posedge mclk_i);
      end
      finish_test();
   end
endmodule : tb

`default_nettype wire
